//--- hw/sost_map.vh
// Register map, field positions, reset values, PC offsets and shift limits
// Assumes inclusion by the operand shifter and status transfer block
`ifndef SOST_MAP_VH
`define SOST_MAP_VH

// Byte offsets on the register bus
`define SOST_OFF_INSTR 8'h00
`define SOST_OFF_OPND 8'h04
`define SOST_OFF_SHREG 8'h08
`define SOST_OFF_IADDR 8'h0C
`define SOST_OFF_ALURES 8'h10
`define SOST_OFF_ALUFLG 8'h14
`define SOST_OFF_CTRL 8'h18
`define SOST_OFF_CUR 8'h1C
`define SOST_OFF_SAVED 8'h20
`define SOST_OFF_SHOUT 8'h24
`define SOST_OFF_INFO 8'h28
`define SOST_OFF_PCOP 8'h2C
`define SOST_OFF_DEST 8'h30

// Status word fields
`define SOST_FLAG_HI 31
`define SOST_FLAG_LO 28
`define SOST_CARRY_BIT 29
`define SOST_MODE_USR 5'h10
`define SOST_MODE_FIQ 5'h11
`define SOST_MODE_IRQ 5'h12
`define SOST_MODE_SVC 5'h13
`define SOST_MODE_ABT 5'h17
`define SOST_MODE_UND 5'h1B
`define SOST_CUR_RST 32'h000000D3
`define SOST_SAVED_RST 32'h00000000
`define SOST_NO_SAVED 3'h7
`define SOST_NUM_SAVED 5

// Result information word fields
`define SOST_INFO_CARRY 0
`define SOST_INFO_UNDEF 1
`define SOST_INFO_BADRS 2
`define SOST_INFO_PCW 3
`define SOST_INFO_DESTW 4
`define SOST_INFO_S_LO 5
`define SOST_INFO_S_HI 6
`define SOST_INFO_N 7
`define SOST_INFO_I 8

// Program counter read-ahead and shift limits
`define SOST_PC_AHEAD_IMM 32'h00000008
`define SOST_PC_AHEAD_REG 32'h0000000C
`define SOST_SH_FULL 8'h20
`define SOST_PC_REG 4'hF

`endif

//--- hw/sost_top.v
// Second-operand barrel shifter and status word transfer datapath
// Assumes an Avalon-MM master, one 50 MHz clock, synchronous reset
// Function
// - Shift amount from low byte, never PC
// - Zero register amount passes operand, old carry
// - Amounts 1..31 match encoded shift
// - Left shift 32 carry bit0, beyond zero
// - Right shift 32 carry bit31, beyond zero
// - Arithmetic shift 32+ fills sign, carry sign
// - Rotate by 32 unchanged, carry bit31
// - Rotate above 32 reduced modulo 32
// - Register shift with bit7 set is undefined
// - Immediate zero-extended, rotated by twice field
// - PC destination without S keeps status
// - PC destination with S restores saved word
// - PC operand is address plus 8 or 12
// - Test and compare set flags, no destination
// - Legacy restore form copies saved when privileged
// - Cycle counts per shift and PC write
// - Status transfers are flagless test opcodes
// - Status read and write move whole words
// - Flag-only write moves top four bits
// - User mode may change flags only
// - Saved word chosen by current mode
// - Encoded shift amount is five bits
module sost_top (
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire [7:0] i_address,
	input wire i_read,
	input wire i_write,
	input wire [31:0] i_writedata,
	input wire [3:0] i_byteenable,
	output reg [31:0] o_readdata,
	output wire o_waitrequest
);
`include "sost_map.vh"

	reg [31:0] instr;
	reg [31:0] opnd;
	reg [31:0] shreg;
	reg [31:0] iaddr;
	reg [31:0] alu_res;
	reg [3:0] alu_flg;
	reg [31:0] cur_sw;
	reg [31:0] saved_sw [0:`SOST_NUM_SAVED-1];
	reg [31:0] sh_out;
	reg [31:0] pc_out;
	reg [31:0] dest_val;
	reg [8:0] info;
	reg ack;

	// Merge bytes of a write under the byte enables
	function [31:0] sost_be;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0] be;
		integer k;
		begin
			sost_be = old_v;
			for (k = 0; k < 4; k = k + 1) begin
				if (be[k]) begin
					sost_be[k*8 +: 8] = new_v[k*8 +: 8];
				end
			end
		end
	endfunction

	// Saved word slot for a mode, none for user or unknown
	function [2:0] sost_slot;
		input [4:0] m;
		begin
			case (m)
				`SOST_MODE_FIQ: sost_slot = 3'h0;
				`SOST_MODE_IRQ: sost_slot = 3'h1;
				`SOST_MODE_SVC: sost_slot = 3'h2;
				`SOST_MODE_ABT: sost_slot = 3'h3;
				`SOST_MODE_UND: sost_slot = 3'h4;
				default: sost_slot = `SOST_NO_SAVED;
			endcase
		end
	endfunction

	// Bus handshake: one wait cycle, then accept
	wire bus_req = i_read | i_write;
	assign o_waitrequest = bus_req & ~ack;
	// Accept edge: the second edge of a held request
	wire bus_take = bus_req & ack;
	// Only writes store at the accept edge
	wire wr_take = bus_take & i_write;
	wire [7:0] waddr = {i_address[7:2], 2'b00};
	wire exec = wr_take & (waddr == `SOST_OFF_CTRL) & i_byteenable[0] & i_writedata[0];

	// Instruction fields
	wire [3:0] opc = instr[24:21];
	wire s_bit = instr[20];
	wire imm_bit = instr[25];
	wire [3:0] rd = instr[15:12];
	wire [3:0] rs = instr[11:8];
	wire [3:0] rm = instr[3:0];
	wire [1:0] sh_type = instr[6:5];
	wire [4:0] enc_amt = instr[11:7];
	wire dp_class = (instr[27:26] == 2'b00);
	wire reg_shift = ~imm_bit & instr[4];
	wire mul_undef = dp_class & reg_shift & instr[7];
	wire bad_rs = dp_class & reg_shift & (rs == `SOST_PC_REG);
	wire test_op = (opc[3:2] == 2'b10);
	wire psr_op = dp_class & ~mul_undef & test_op & ~s_bit;
	wire read_op = psr_op & ~opc[0];
	wire write_op = psr_op & opc[0];
	wire use_saved = opc[1];
	wire whole_wr = instr[16];
	wire dp_op = dp_class & ~mul_undef & ~bad_rs & ~psr_op;
	wire logic_op = (opc[3:1] == 3'b000) | (opc[3:1] == 3'b100) | (opc[3:2] == 2'b11);
	wire legacy = test_op & (opc == 4'h9) & (rd == `SOST_PC_REG);

	// Mode and saved word of the mode in force
	wire [4:0] mode = cur_sw[4:0];
	wire user = (mode == `SOST_MODE_USR);
	wire [2:0] slot = sost_slot(mode);
	wire has_saved = (slot != `SOST_NO_SAVED);
	wire [31:0] saved_cur = has_saved ? saved_sw[slot] : 32'h00000000;

	// Program counter as operand, with prefetch offset
	wire [31:0] pc_val = iaddr + (reg_shift ? `SOST_PC_AHEAD_REG : `SOST_PC_AHEAD_IMM);
	wire [31:0] op_val = (rm == `SOST_PC_REG) ? pc_val : opnd;
	wire cin = cur_sw[`SOST_CARRY_BIT];
	wire [7:0] amt = reg_shift ? shreg[7:0] : {3'h0, enc_amt};

	// Barrel shifter
	reg [31:0] sh_res;
	reg sh_c;
	reg [32:0] t33;
	reg signed [32:0] s33;
	reg [63:0] t64;
	reg [4:0] rot;
	always @* begin
		t33 = 33'h000000000;
		s33 = 33'sh000000000;
		t64 = {op_val, op_val};
		rot = 5'h00;
		sh_res = op_val;
		sh_c = cin;
		if (imm_bit) begin
			rot = {instr[11:8], 1'b0};
			t64 = {24'h000000, instr[7:0], 24'h000000, instr[7:0]} >> rot;
			sh_res = t64[31:0];
			sh_c = (rot == 5'h00) ? cin : t64[31];
		end else if (~reg_shift && enc_amt == 5'h00) begin
			case (sh_type)
				2'b00: begin
					sh_res = op_val;
					sh_c = cin;
				end
				2'b01: begin
					sh_res = 32'h00000000;
					sh_c = op_val[31];
				end
				2'b10: begin
					sh_res = {32{op_val[31]}};
					sh_c = op_val[31];
				end
				default: begin
					sh_res = {cin, op_val[31:1]};
					sh_c = op_val[0];
				end
			endcase
		end else if (reg_shift && amt == 8'h00) begin
			sh_res = op_val;
			sh_c = cin;
		end else begin
			// Amounts 1..31 share the encoded path
			case (sh_type)
				2'b00: begin
					if (amt > `SOST_SH_FULL) begin
						sh_res = 32'h00000000;
						sh_c = 1'b0;
					end else begin
						t33 = {1'b0, op_val} << amt[5:0];
						sh_res = t33[31:0];
						sh_c = t33[32];
					end
				end
				2'b01: begin
					if (amt > `SOST_SH_FULL) begin
						sh_res = 32'h00000000;
						sh_c = 1'b0;
					end else begin
						t33 = {op_val, 1'b0} >> amt[5:0];
						sh_res = t33[32:1];
						sh_c = t33[0];
					end
				end
				2'b10: begin
					if (amt >= `SOST_SH_FULL) begin
						sh_res = {32{op_val[31]}};
						sh_c = op_val[31];
					end else begin
						s33 = $signed({op_val, 1'b0}) >>> amt[4:0];
						sh_res = s33[32:1];
						sh_c = s33[0];
					end
				end
				default: begin
					rot = amt[4:0];
					t64 = {op_val, op_val} >> rot;
					sh_res = t64[31:0];
					sh_c = t64[31];
				end
			endcase
		end
	end

	// Execute: destination, status word and saved word updates
	reg [31:0] next_cur;
	reg [31:0] next_dest;
	reg next_sav_we;
	reg [31:0] next_sav;
	reg next_pcw;
	reg next_destw;
	reg [31:0] src;
	always @* begin
		next_cur = cur_sw;
		next_dest = dest_val;
		next_sav_we = 1'b0;
		next_sav = saved_cur;
		next_pcw = 1'b0;
		next_destw = 1'b0;
		src = imm_bit ? sh_res : opnd;
		if (read_op) begin
			next_dest = use_saved ? saved_cur : cur_sw;
			next_destw = 1'b1;
		end else if (write_op) begin
			if (use_saved) begin
				if (has_saved) begin
					next_sav_we = 1'b1;
					if (whole_wr) begin
						next_sav = src;
					end else begin
						next_sav = {src[31:28], saved_cur[27:0]};
					end
				end
			end else if (whole_wr && !user) begin
				next_cur = src;
			end else begin
				next_cur = {src[31:28], cur_sw[27:0]};
			end
		end else if (dp_op) begin
			if (test_op) begin
				if (legacy) begin
					if (!user && has_saved) begin
						next_cur = saved_cur;
					end
				end else if (logic_op) begin
					next_cur = {alu_res[31], alu_res == 32'h00000000, sh_c, cur_sw[28:0]};
				end else begin
					next_cur = {alu_flg, cur_sw[27:0]};
				end
			end else begin
				next_dest = alu_res;
				next_destw = 1'b1;
				if (rd == `SOST_PC_REG) begin
					next_pcw = 1'b1;
					if (s_bit && has_saved) begin
						next_cur = saved_cur;
					end
				end else if (s_bit) begin
					if (logic_op) begin
						next_cur = {alu_res[31], alu_res == 32'h00000000, sh_c, cur_sw[28:0]};
					end else begin
						next_cur = {alu_flg, cur_sw[27:0]};
					end
				end
			end
		end
	end

	// Cycle counts: S, N and I
	wire [1:0] cyc_s = next_pcw ? 2'h2 : 2'h1;
	wire cyc_n = next_pcw;
	wire cyc_i = dp_op & reg_shift;

	// Saved word write from execute or bus
	wire bus_sav = wr_take & (waddr == `SOST_OFF_SAVED) & has_saved;
	wire sav_wr = (exec & next_sav_we) | bus_sav;
	wire [31:0] sav_data = exec ? next_sav : sost_be(saved_cur, i_writedata, i_byteenable);

	// One saved word per privileged mode
	genvar g;
	generate
		for (g = 0; g < `SOST_NUM_SAVED; g = g + 1) begin : g_saved
			always @(posedge i_ref_clk) begin
				if (!i_rst_n) begin
					saved_sw[g] <= `SOST_SAVED_RST;
				end else if (sav_wr && slot == g) begin
					saved_sw[g] <= sav_data;
				end
			end
		end
	endgenerate

	// Handshake, bus writes and execute results
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			ack <= 1'b0;
			instr <= 32'h00000000;
			opnd <= 32'h00000000;
			shreg <= 32'h00000000;
			iaddr <= 32'h00000000;
			alu_res <= 32'h00000000;
			alu_flg <= 4'h0;
			cur_sw <= `SOST_CUR_RST;
			sh_out <= 32'h00000000;
			pc_out <= 32'h00000000;
			dest_val <= 32'h00000000;
			info <= 9'h000;
		end else begin
			ack <= bus_req & ~ack;
			if (wr_take) begin
				case (waddr)
					`SOST_OFF_INSTR: instr <= sost_be(instr, i_writedata, i_byteenable);
					`SOST_OFF_OPND: opnd <= sost_be(opnd, i_writedata, i_byteenable);
					`SOST_OFF_SHREG: shreg <= sost_be(shreg, i_writedata, i_byteenable);
					`SOST_OFF_IADDR: iaddr <= sost_be(iaddr, i_writedata, i_byteenable);
					`SOST_OFF_ALURES: alu_res <= sost_be(alu_res, i_writedata, i_byteenable);
					`SOST_OFF_ALUFLG: begin
						if (i_byteenable[0]) begin
							alu_flg <= i_writedata[3:0];
						end
					end
					`SOST_OFF_CUR: cur_sw <= sost_be(cur_sw, i_writedata, i_byteenable);
					default: begin
					end
				endcase
			end
			if (exec) begin
				cur_sw <= next_cur;
				sh_out <= sh_res;
				pc_out <= pc_val;
				dest_val <= next_dest;
				info <= {cyc_i, cyc_n, cyc_s, next_destw, next_pcw, bad_rs, mul_undef, sh_c};
			end
		end
	end

	// Registered read data
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_readdata <= 32'h00000000;
		end else if (i_read && !ack) begin
			case ({i_address[7:2], 2'b00})
				`SOST_OFF_INSTR: o_readdata <= instr;
				`SOST_OFF_OPND: o_readdata <= opnd;
				`SOST_OFF_SHREG: o_readdata <= shreg;
				`SOST_OFF_IADDR: o_readdata <= iaddr;
				`SOST_OFF_ALURES: o_readdata <= alu_res;
				`SOST_OFF_ALUFLG: o_readdata <= {28'h0000000, alu_flg};
				`SOST_OFF_CUR: o_readdata <= cur_sw;
				`SOST_OFF_SAVED: o_readdata <= saved_cur;
				`SOST_OFF_SHOUT: o_readdata <= sh_out;
				`SOST_OFF_INFO: o_readdata <= {23'h000000, info};
				`SOST_OFF_PCOP: o_readdata <= pc_out;
				`SOST_OFF_DEST: o_readdata <= dest_val;
				default: o_readdata <= 32'h00000000;
			endcase
		end
	end

endmodule // sost_top

//--- bench/sost_asserts.sv
// Bus and result checks for the operand shifter status block
// Sees only the top ports; bound to every sost_top instance
`include "sost_map.vh"
module sost_asserts (
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire [7:0] i_address,
	input wire i_read,
	input wire i_write,
	input wire [31:0] i_writedata,
	input wire [3:0] i_byteenable,
	input wire [31:0] o_readdata,
	input wire o_waitrequest
);
	wire req = i_read | i_write;
	wire acc = req & ~o_waitrequest;
	wire rda = acc & i_read;
	wire [7:0] wa = {i_address[7:2], 2'h0};
	reg [31:0] iaddr;
	reg [31:0] base;
	reg ran;
	reg rsh;
	reg rsh_x;
	// Track address and shift kind in force at the last execute
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			iaddr <= 32'h0;
			base <= 32'h0;
			ran <= 1'b0;
			rsh <= 1'b0;
			rsh_x <= 1'b0;
		end else if (acc && i_write && wa == `SOST_OFF_IADDR) begin
			iaddr <= i_writedata;
		end else if (acc && i_write && wa == `SOST_OFF_INSTR) begin
			rsh <= ~i_writedata[25] & i_writedata[4];
		end else if (acc && i_write && wa == `SOST_OFF_CTRL && i_writedata[0]) begin
			base <= iaddr;
			rsh_x <= rsh;
			ran <= 1'b1;
		end
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	a_wait_once: assert property (req && o_waitrequest ##1 req |-> !o_waitrequest)
		else $error("request waited more than one cycle");
	a_accept_late: assert property (acc |-> $past(req && o_waitrequest))
		else $error("request accepted without a wait cycle");
	a_rdata_hold: assert property (!(i_read && o_waitrequest) |=> $stable(o_readdata))
		else $error("read data moved without a read");
	a_ctrl_zero: assert property (rda && wa == `SOST_OFF_CTRL |-> o_readdata == 32'h0)
		else $error("control word read not zero");
	a_unmapped_zero: assert property (rda && wa > `SOST_OFF_DEST |-> o_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_pc_ahead: assert property (rda && ran && wa == `SOST_OFF_PCOP |->
		o_readdata == base + (rsh_x ? `SOST_PC_AHEAD_REG : `SOST_PC_AHEAD_IMM))
		else $error("program counter operand offset wrong");
	a_ncyc_pcw: assert property (rda && wa == `SOST_OFF_INFO |-> o_readdata[7] == o_readdata[3])
		else $error("N cycle does not follow PC write");
	a_scyc_count: assert property (rda && ran && wa == `SOST_OFF_INFO && o_readdata[2:1] == 2'h0
		|-> o_readdata[6:5] == (o_readdata[3] ? 2'h2 : 2'h1))
		else $error("S cycle count wrong");
	c_exec: cover property (acc && i_write && wa == `SOST_OFF_CTRL);
	c_pcop: cover property (rda && ran && wa == `SOST_OFF_PCOP);
	c_info: cover property (rda && ran && wa == `SOST_OFF_INFO);
endmodule // sost_asserts

bind sost_top sost_asserts sost_asserts_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
	.i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
	.i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest));

//--- bench/sost_bench.sv
// Self-checking bench for the operand shifter status block
// Acts as Avalon-MM master; needs sost_map.vh on the include path
`include "sost_map.vh"
module sost_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam [31:0] ALL = 32'hFFFFFFFF;
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg rdq = 1'b0;
	reg we = 1'b0;
	reg [7:0] adr = 8'h0;
	reg [31:0] wd = 32'h0;
	reg [31:0] q;
	reg [7:0] am [7] = '{8'h01, 8'h1F, 8'h00, 8'h20, 8'h21, 8'h40, 8'hFF};
	wire [31:0] rdata;
	wire wq;
	int num_errors = 0;
	int checked = 0;
	int cyc = 0;
	sost_top sost_top_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_address(adr), .i_read(rdq),
		.i_write(we), .i_writedata(wd), .i_byteenable(4'hF), .o_readdata(rdata),
		.o_waitrequest(wq));
	// 50 MHz clock
	initial forever #10 clk = ~clk;
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			num_errors++;
			give_verdict;
		end
	end
	task give_verdict;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task chk(input string n, input [31:0] g, input [31:0] e);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// One bus cycle, held until waitrequest is seen low at a rising edge
	task xfer(input r, input [7:0] a, input [31:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		rdq <= r;
		we <= ~r;
		do @(posedge clk); while (wq !== 1'b0);
		q = rdata;
		rdq <= 1'b0;
		we <= 1'b0;
	endtask
	task wr(input [7:0] a, input [31:0] d);
		xfer(1'b0, a, d);
	endtask
	task rc(input [7:0] a, input string n, input [31:0] m, input [31:0] e);
		xfer(1'b1, a, 32'h0);
		chk(n, q & m, e);
	endtask
	task ex(input [31:0] i);
		wr(`SOST_OFF_INSTR, i);
		wr(`SOST_OFF_CTRL, 32'h1);
	endtask
	function [31:0] ins(input [3:0] o, input s, input [3:0] n, input [3:0] d,
		input [11:0] p, input i);
		return {4'hE, 2'h0, i, o, s, n, d, p};
	endfunction
	// Expected shifter carry and result for a register amount
	function [32:0] sref(input [1:0] t, input [7:0] a, input [31:0] x, input c);
		reg [63:0] w;
		if (a == 8'h00) return {c, x};
		case (t)
			2'h0: return {1'b0, x} << a;
			2'h1: w = {x, 32'h0} >> a;
			2'h2: w = $signed({x, 32'h0}) >>> (a > 8'h20 ? 8'h20 : a);
			default: w = {x, x} >> a[4:0];
		endcase
		return {w[31], t == 2'h3 ? w[31:0] : w[63:32]};
	endfunction
	task t_reset;
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rc(`SOST_OFF_CUR, "cur_rst", ALL, 32'hD3);
		rc(`SOST_OFF_CTRL, "ctrl", ALL, 32'h0);
		rc(8'h3C, "unmapped", ALL, 32'h0);
		wr(`SOST_OFF_IADDR, 32'h100);
	endtask
	task t_shift;
		reg [31:0] x;
		reg [32:0] e;
		for (int t = 0; t < 4; t++) begin
			for (int k = 0; k < 7; k++) begin
				x = k[0] ? 32'hC0000005 : 32'h3FFFFFFA;
				e = sref(t[1:0], am[k], x, k[1]);
				wr(`SOST_OFF_OPND, x);
				wr(`SOST_OFF_SHREG, {24'hA5A5A5, am[k]});
				wr(`SOST_OFF_CUR, {2'h0, k[1], 29'hD3});
				ex(ins(4'hD, 1'b0, 4'h0, 4'h1, {4'h2, 1'b0, t[1:0], 1'b1, 4'h3}, 1'b0));
				rc(`SOST_OFF_SHOUT, "shout", ALL, e[31:0]);
				rc(`SOST_OFF_INFO, "info", 32'h1FF, {23'h0, 8'h98, e[32]});
				rc(`SOST_OFF_PCOP, "pcop_reg", ALL, 32'h10C);
			end
		end
	endtask
	task t_imm;
		reg [63:0] w;
		for (int r = 0; r < 16; r++) begin
			w = {32'hC3, 32'hC3} >> (2 * r);
			ex(ins(4'hD, 1'b0, 4'h0, 4'h1, {r[3:0], 8'hC3}, 1'b1));
			rc(`SOST_OFF_SHOUT, "imm", ALL, w[31:0]);
			rc(`SOST_OFF_PCOP, "pcop_imm", ALL, 32'h108);
		end
	endtask
	task t_misc;
		ex(ins(4'hD, 1'b0, 4'h0, 4'h1, 12'hF13, 1'b0));
		rc(`SOST_OFF_INFO, "rs_pc", 32'h14, 32'h4);
		ex(ins(4'hD, 1'b0, 4'h0, 4'h1, 12'h293, 1'b0));
		rc(`SOST_OFF_INFO, "bit7", 32'h12, 32'h2);
		wr(`SOST_OFF_CUR, 32'hD3);
		wr(`SOST_OFF_ALURES, 32'h2468);
		wr(`SOST_OFF_SAVED, 32'hA0000011);
		ex(ins(4'hD, 1'b0, 4'h0, 4'hF, 12'h001, 1'b1));
		rc(`SOST_OFF_CUR, "pc_keep", ALL, 32'hD3);
		rc(`SOST_OFF_DEST, "pc_dest", ALL, 32'h2468);
		rc(`SOST_OFF_INFO, "cyc_pc", 32'h1E8, 32'hC8);
		ex(ins(4'hD, 1'b0, 4'h0, 4'hF, 12'h213, 1'b0));
		rc(`SOST_OFF_INFO, "cyc_pc_reg", 32'h1E8, 32'h1C8);
		ex(ins(4'hD, 1'b1, 4'h0, 4'hF, 12'h001, 1'b1));
		rc(`SOST_OFF_CUR, "pc_restore", ALL, 32'hA0000011);
		wr(`SOST_OFF_ALURES, 32'h80000000);
		wr(`SOST_OFF_ALUFLG, 32'h9);
		for (int o = 8; o < 12; o++) begin
			wr(`SOST_OFF_CUR, 32'h100000D3);
			ex(ins(o[3:0], 1'b1, 4'h0, 4'h1, 12'h101, 1'b1));
			rc(`SOST_OFF_CUR, "test_flags", ALL, 32'h900000D3);
			rc(`SOST_OFF_INFO, "test_nodest", 32'h10, 32'h0);
		end
	endtask
	task t_status;
		wr(`SOST_OFF_SAVED, 32'h600000D3);
		ex(ins(4'h8, 1'b0, 4'h0, 4'h1, 12'h0, 1'b0));
		rc(`SOST_OFF_DEST, "read_cur", ALL, 32'h900000D3);
		ex(ins(4'hA, 1'b0, 4'h0, 4'h1, 12'h0, 1'b0));
		rc(`SOST_OFF_DEST, "read_saved", ALL, 32'h600000D3);
		ex(ins(4'h9, 1'b0, 4'h0, 4'h0, 12'h4F0, 1'b1));
		rc(`SOST_OFF_CUR, "flags_only", ALL, 32'hF00000D3);
		wr(`SOST_OFF_OPND, 32'h200000D1);
		ex(ins(4'hB, 1'b0, 4'h1, 4'h0, 12'h003, 1'b0));
		rc(`SOST_OFF_SAVED, "write_saved", ALL, 32'h200000D1);
		ex(ins(4'h9, 1'b1, 4'h0, 4'hF, 12'h0, 1'b1));
		rc(`SOST_OFF_CUR, "legacy_priv", ALL, 32'h200000D1);
		wr(`SOST_OFF_CUR, {q[31:5], 5'h10});
		rc(`SOST_OFF_SAVED, "usr_saved", ALL, 32'h0);
		wr(`SOST_OFF_OPND, 32'hF00000D3);
		ex(ins(4'h9, 1'b0, 4'h1, 4'h0, 12'h003, 1'b0));
		rc(`SOST_OFF_CUR, "usr_write", ALL, 32'hF00000D0);
		ex(ins(4'h9, 1'b1, 4'h0, 4'hF, 12'h0, 1'b1));
		rc(`SOST_OFF_CUR, "legacy_usr", ALL, 32'hF00000D0);
	endtask
	// Main sequence, ending with a second reset
	initial begin
		@(posedge clk);
		t_reset;
		t_shift;
		t_imm;
		t_misc;
		t_status;
		t_reset;
		give_verdict;
	end
endmodule // sost_bench
